// file: dicr_regs.sv
/*
 * read-only identity and capability register bank.
 * assumes a plain register port on core_clk: read data one cycle
 * after the read strobe; per-device straps are steady at reset.
 */
module dicr_regs (
    input  wire logic                  core_clk,
    input  wire logic                  reset,
    input  wire logic                  clk_en,
    input  wire dicr_pkg::dicr_strap_t strap_in,
    input  wire logic [11:0]           addr,
    input  wire logic [31:0]           wdata,
    input  wire logic                  wr_stb,
    input  wire logic                  rd_stb,
    output logic      [31:0]           rdata,
    output logic                       rd_miss,
    output logic                       straps_valid
);
    // ==========================================================
    // per-device values
    // ==========================================================
    logic                  cap_done;
    dicr_pkg::dicr_strap_t strap_q;

    dicr_strap_latch u_strap (
        .core_clk (core_clk),
        .strap_in (strap_in),
        .reset    (reset),
        .clk_en   (clk_en),
        .captured (cap_done),
        .strap_q  (strap_q)
    );

    // ==========================================================
    // fixed words and the strap-fed identity word
    // ==========================================================
    dicr_pkg::dicr_identity_t    id_w;
    dicr_pkg::dicr_core_feat_t   core_w;
    dicr_pkg::dicr_periph_feat_t per_w;
    logic [31:0]                 mem_w;

    // identity word assembly
    always_comb begin
        id_w                     = '0;
        id_w.format_revision     = dicr_pkg::FORMAT_REV_INIT;
        id_w.product_line_code   = dicr_pkg::PRODUCT_LINE;
        id_w.product_number_code = dicr_pkg::PRODUCT_NUMBER;
        id_w.thermal_grade       = strap_q.thermal_grade;
        id_w.housing_type        = dicr_pkg::HOUSING_QFP48;
        id_w.lead_free_flag      = dicr_pkg::LEAD_FREE;
        id_w.release_status      = strap_q.release_status;
    end

    // memory capability word
    assign mem_w = {dicr_pkg::RAM_CAP_8K, dicr_pkg::NVM_CAP_32K};

    // core feature word assembly
    always_comb begin
        core_w                           = '0;
        core_w.min_core_clock_divisor    = dicr_pkg::MIN_DIV_CODE;
        core_w.watchdog_present          = 1'b1;
        core_w.trace_output_present      = 1'b1;
        core_w.two_wire_debug_present    = 1'b1;
        core_w.scan_debug_present        = 1'b1;
        core_w.memory_protection_present = 1'b1;
        core_w.pll_present               = 1'b1;
    end

    // peripheral feature word assembly
    always_comb begin
        per_w                       = '0;
        per_w.comparator_present    = 3'h7;
        per_w.sync_serial0_present  = 1'b1;
        per_w.async_serial1_present = 1'b1;
        per_w.async_serial0_present = 1'b1;
        per_w.gp_count_present      = 3'h7;
        per_w.two_wire_bus0_present = 1'b1;
    end

    // ==========================================================
    // read port
    // ==========================================================
    logic [31:0] mux_data;
    logic        mux_hit;

    dicr_read_mux u_mux (
        .addr                    (addr),
        .identity_word           (id_w),
        .memory_capability_word  (mem_w),
        .core_feature_word       (core_w),
        .peripheral_feature_word (per_w),
        .rdata                   (mux_data),
        .hit                     (mux_hit)
    );

    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic        miss_ff;
    logic        nxt_miss;
    logic        valid_ff;
    logic        nxt_valid;

    // read data for one cycle after strobe; writes have no effect
    always_comb begin
        nxt_rdata = 32'h00000000;
        nxt_miss  = 1'b0;
        nxt_valid = cap_done;
        if (rd_stb) begin
            nxt_rdata = mux_data;
            nxt_miss  = !mux_hit;
        end
        if (!clk_en) begin
            nxt_rdata = rdata_ff;
            nxt_miss  = miss_ff;
            nxt_valid = valid_ff;
        end
    end

    // registers only
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rdata_ff <= 32'h00000000;
            miss_ff  <= 1'b0;
            valid_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            miss_ff  <= nxt_miss;
            valid_ff <= nxt_valid;
        end
    end

    assign rdata        = rdata_ff;
    assign rd_miss      = miss_ff;
    assign straps_valid = valid_ff;

    // ==========================================================
    // checks
    // ==========================================================
    // write strobe and data are deliberately unused: words are read only
    logic        wr_seen;
    assign wr_seen = wr_stb & |wdata;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    id_fixed_a: assert property (clk_en && rd_stb && addr == dicr_pkg::OFS_IDENTITY |=>
        rdata[31:16] == {dicr_pkg::FORMAT_REV_INIT, dicr_pkg::PRODUCT_LINE, dicr_pkg::PRODUCT_NUMBER})
        else $error("identity upper half wrong");
    id_pkg_a: assert property (clk_en && rd_stb && addr == dicr_pkg::OFS_IDENTITY |=>
        rdata[4:2] == {dicr_pkg::HOUSING_QFP48, dicr_pkg::LEAD_FREE} && rdata[15:8] == 8'h00)
        else $error("identity housing or reserved wrong");
    id_strap_a: assert property (clk_en && rd_stb && addr == dicr_pkg::OFS_IDENTITY |=>
        rdata[7:5] == $past(strap_q.thermal_grade) && rdata[1:0] == $past(strap_q.release_status))
        else $error("identity per-device fields wrong");
    mem_word_a: assert property (clk_en && rd_stb && addr == dicr_pkg::OFS_MEMORY |=>
        rdata == 32'h001F000F)
        else $error("memory word wrong");
    core_word_a: assert property (clk_en && rd_stb && addr == dicr_pkg::OFS_CORE_FEAT |=>
        rdata == 32'h0000309F)
        else $error("core feature word wrong");
    periph_word_a: assert property (clk_en && rd_stb && addr == dicr_pkg::OFS_PERIPH_FEAT |=>
        rdata == 32'h07071013)
        else $error("peripheral feature word wrong");
    read_once_a: assert property (clk_en && !rd_stb |=> rdata == 32'h00000000)
        else $error("read data outside answer cycle");
    write_ignore_a: assert property (clk_en && wr_seen && !rd_stb ##1 clk_en && rd_stb
        && addr == dicr_pkg::OFS_MEMORY |=> rdata == 32'h001F000F)
        else $error("write altered a word");

    // ==========================================================
    // field-level checks
    // ==========================================================
    // product-line code sits in bits 27:24
    id_line_a: assert property (clk_en && rd_stb && addr == dicr_pkg::OFS_IDENTITY |=>
        rdata[27:24] == dicr_pkg::PRODUCT_LINE)
        else $error("product line code wrong");

    // product-number code sits in bits 23:16
    id_number_a: assert property (clk_en && rd_stb && addr == dicr_pkg::OFS_IDENTITY |=>
        rdata[23:16] == dicr_pkg::PRODUCT_NUMBER)
        else $error("product number code wrong");

    // lead-free flag reads one
    id_lead_a: assert property (clk_en && rd_stb && addr == dicr_pkg::OFS_IDENTITY |=>
        rdata[2] == dicr_pkg::LEAD_FREE)
        else $error("lead-free flag wrong");

    // identity reserved byte reads zero
    id_rsvd_a: assert property (clk_en && rd_stb && addr == dicr_pkg::OFS_IDENTITY |=>
        rdata[15:8] == 8'h00)
        else $error("identity reserved byte not zero");

    // thermal grade follows the strap pins once captured
    id_grade_a: assert property (clk_en && rd_stb && straps_valid && addr == dicr_pkg::OFS_IDENTITY |=>
        rdata[7:5] == $past(strap_in.thermal_grade))
        else $error("thermal grade does not follow straps");

    // release status follows the strap pins once captured
    id_status_a: assert property (clk_en && rd_stb && straps_valid && addr == dicr_pkg::OFS_IDENTITY |=>
        rdata[1:0] == $past(strap_in.release_status))
        else $error("release status does not follow straps");

    // upper half of the memory word is the RAM size code
    mem_ram_a: assert property (clk_en && rd_stb && addr == dicr_pkg::OFS_MEMORY |=>
        rdata[31:16] == dicr_pkg::RAM_CAP_8K)
        else $error("RAM size code wrong");

    // lower half of the memory word is the flash size code
    mem_nvm_a: assert property (clk_en && rd_stb && addr == dicr_pkg::OFS_MEMORY |=>
        rdata[15:0] == dicr_pkg::NVM_CAP_32K)
        else $error("flash size code wrong");

    // minimum divisor code in bits 15:12
    core_div_a: assert property (clk_en && rd_stb && addr == dicr_pkg::OFS_CORE_FEAT |=>
        rdata[15:12] == dicr_pkg::MIN_DIV_CODE)
        else $error("minimum divisor code wrong");

    // watchdog, trace and both debug ports present
    core_debug_a: assert property (clk_en && rd_stb && addr == dicr_pkg::OFS_CORE_FEAT |=>
        rdata[3:0] == 4'hF)
        else $error("watchdog, trace or debug bit wrong");

    // protection unit and PLL present
    core_extra_a: assert property (clk_en && rd_stb && addr == dicr_pkg::OFS_CORE_FEAT |=>
        rdata[7] && rdata[4])
        else $error("protection or PLL bit wrong");

    // core word reserved fields read zero
    core_rsvd_a: assert property (clk_en && rd_stb && addr == dicr_pkg::OFS_CORE_FEAT |=>
        rdata[31:16] == 16'h0000 && rdata[11:8] == 4'h0 && rdata[6:5] == 2'h0)
        else $error("core word reserved bits not zero");

    // three comparators present
    per_comp_a: assert property (clk_en && rd_stb && addr == dicr_pkg::OFS_PERIPH_FEAT |=>
        rdata[26:24] == 3'h7)
        else $error("comparator bits wrong");

    // synchronous serial zero present
    per_sync_a: assert property (clk_en && rd_stb && addr == dicr_pkg::OFS_PERIPH_FEAT |=>
        rdata[4])
        else $error("synchronous serial bit wrong");

    // both asynchronous serial modules present
    per_async_a: assert property (clk_en && rd_stb && addr == dicr_pkg::OFS_PERIPH_FEAT |=>
        rdata[1:0] == 2'h3)
        else $error("asynchronous serial bits wrong");

    // three timers and the two-wire bus present
    per_extra_a: assert property (clk_en && rd_stb && addr == dicr_pkg::OFS_PERIPH_FEAT |=>
        rdata[18:16] == 3'h7 && rdata[12])
        else $error("timer or two-wire bus bit wrong");

    // peripheral word reserved fields read zero
    per_rsvd_a: assert property (clk_en && rd_stb && addr == dicr_pkg::OFS_PERIPH_FEAT |=>
        rdata[31:27] == 5'h00 && rdata[23:19] == 5'h00 && rdata[15:13] == 3'h0
        && rdata[11:5] == 7'h00 && rdata[3:2] == 2'h0)
        else $error("peripheral word reserved bits not zero");

    // miss flag only answers a strobe
    miss_idle_a: assert property (clk_en && !rd_stb |=> !rd_miss)
        else $error("miss flag outside answer cycle");

    // mapped offsets never flag a miss
    hit_no_miss_a: assert property (clk_en && rd_stb && (addr == dicr_pkg::OFS_IDENTITY
        || addr == dicr_pkg::OFS_MEMORY || addr == dicr_pkg::OFS_CORE_FEAT
        || addr == dicr_pkg::OFS_PERIPH_FEAT) |=> !rd_miss)
        else $error("mapped offset flagged a miss");

    // unmapped offsets answer zero with a miss
    unmapped_zero_a: assert property (clk_en && rd_stb && addr != dicr_pkg::OFS_IDENTITY
        && addr != dicr_pkg::OFS_MEMORY && addr != dicr_pkg::OFS_CORE_FEAT
        && addr != dicr_pkg::OFS_PERIPH_FEAT |=> rd_miss && rdata == 32'h00000000)
        else $error("unmapped read not zero with miss");

    // low clock enable freezes every output
    freeze_hold_a: assert property (!clk_en |=>
        $stable(rdata) && $stable(rd_miss) && $stable(straps_valid))
        else $error("outputs moved with clock enable low");

    // capture flag stays up until the next reset
    valid_stay_a: assert property (straps_valid |=> straps_valid)
        else $error("strap capture flag dropped");

    // ==========================================================
    // coverage
    // ==========================================================
    id_read_c:   cover property (clk_en && rd_stb && addr == dicr_pkg::OFS_IDENTITY);
    back_read_c: cover property (clk_en && rd_stb ##1 clk_en && rd_stb);
    miss_read_c: cover property (rd_miss);
    wr_rd_c:     cover property (clk_en && wr_seen ##1 clk_en && rd_stb);
    freeze_c:    cover property (!clk_en && rdata != 32'h00000000);

endmodule : dicr_regs

// file: dicr_pkg.sv
/*
 * package for the device identity and capability register bank:
 * word offsets, field positions and fixed field values.
 * assumes a 32-bit plain register port on the system clock.
 */
package dicr_pkg;

    // ==========================================================
    // register map
    // ==========================================================
    localparam int          ADDR_W          = 12;
    localparam logic [11:0] OFS_IDENTITY    = 12'h004;
    localparam logic [11:0] OFS_MEMORY      = 12'h008;
    localparam logic [11:0] OFS_CORE_FEAT   = 12'h010;
    localparam logic [11:0] OFS_PERIPH_FEAT = 12'h014;

    // ==========================================================
    // identity word fields
    // ==========================================================
    localparam logic [3:0] FORMAT_REV_INIT  = 4'h0;
    localparam logic [3:0] PRODUCT_LINE     = 4'h5;   // arbitrary neutral value
    localparam logic [7:0] PRODUCT_NUMBER   = 8'h5C;  // arbitrary neutral value
    localparam logic [2:0] GRADE_EXTENDED   = 3'h2;
    localparam logic [1:0] HOUSING_QFP48    = 2'h1;
    localparam logic       LEAD_FREE        = 1'b1;
    localparam logic [1:0] STATUS_QUALIFIED = 2'h2;

    // ==========================================================
    // memory capability and divisor values
    // ==========================================================
    localparam logic [15:0] RAM_CAP_8K    = 16'h001F;
    localparam logic [15:0] NVM_CAP_32K   = 16'h000F;
    localparam logic [3:0]  MIN_DIV_CODE  = 4'h3;

    // ==========================================================
    // field layouts
    // ==========================================================
    typedef struct packed {
        logic [3:0] format_revision;
        logic [3:0] product_line_code;
        logic [7:0] product_number_code;
        logic [7:0] rsvd;
        logic [2:0] thermal_grade;
        logic [1:0] housing_type;
        logic       lead_free_flag;
        logic [1:0] release_status;
    } dicr_identity_t;

    typedef struct packed {
        logic [15:0] rsvd_hi;
        logic [3:0]  min_core_clock_divisor;
        logic [3:0]  rsvd_mid;
        logic        memory_protection_present;
        logic [1:0]  rsvd_lo;
        logic        pll_present;
        logic        watchdog_present;
        logic        trace_output_present;
        logic        two_wire_debug_present;
        logic        scan_debug_present;
    } dicr_core_feat_t;

    typedef struct packed {
        logic [4:0] rsvd_a;
        logic [2:0] comparator_present;   // comparator2..0
        logic [4:0] rsvd_b;
        logic [2:0] gp_count_present;     // gp_count2..0
        logic [2:0] rsvd_c;
        logic       two_wire_bus0_present;
        logic [6:0] rsvd_d;
        logic       sync_serial0_present;
        logic [1:0] rsvd_e;
        logic       async_serial1_present;
        logic       async_serial0_present;
    } dicr_periph_feat_t;

    // per-device manufacturing straps
    typedef struct packed {
        logic [2:0] thermal_grade;
        logic [1:0] release_status;
    } dicr_strap_t;

endpackage : dicr_pkg

// file: dicr_strap_latch.sv
/*
 * captures the per-device strap levels one clock after reset release.
 * assumes straps are steady, synchronous to core_clk.
 */
module dicr_strap_latch (
    input  wire logic                core_clk,
    input  wire logic                reset,
    input  wire logic                clk_en,
    input  wire dicr_pkg::dicr_strap_t strap_in,
    output logic                     captured,
    output dicr_pkg::dicr_strap_t    strap_q
);
    // ==========================================================
    // capture once after reset release
    // ==========================================================
    logic                  done_ff;
    logic                  nxt_done;
    dicr_pkg::dicr_strap_t val_ff;
    dicr_pkg::dicr_strap_t nxt_val;

    // next-state: load strap values on first enabled cycle
    always_comb begin
        nxt_done = done_ff;
        nxt_val  = val_ff;
        if (clk_en && !done_ff) begin
            nxt_done = 1'b1;
            nxt_val  = strap_in;
        end
    end

    // registers only
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            done_ff <= 1'b0;
            val_ff  <= '0;
        end else begin
            done_ff <= nxt_done;
            val_ff  <= nxt_val;
        end
    end

    assign captured = done_ff;
    assign strap_q  = val_ff;

endmodule : dicr_strap_latch

// file: dicr_read_mux.sv
/*
 * combinational word selector for the identity and capability bank.
 * assumes the address is already a byte offset within the bank.
 */
module dicr_read_mux (
    input  wire logic [11:0] addr,
    input  wire logic [31:0] identity_word,
    input  wire logic [31:0] memory_capability_word,
    input  wire logic [31:0] core_feature_word,
    input  wire logic [31:0] peripheral_feature_word,
    output logic      [31:0] rdata,
    output logic             hit
);
    // ==========================================================
    // decode
    // ==========================================================
    // unmapped offsets read as zero
    always_comb begin
        rdata = 32'h00000000;
        hit   = 1'b1;
        unique case (addr)
            dicr_pkg::OFS_IDENTITY:    rdata = identity_word;
            dicr_pkg::OFS_MEMORY:      rdata = memory_capability_word;
            dicr_pkg::OFS_CORE_FEAT:   rdata = core_feature_word;
            dicr_pkg::OFS_PERIPH_FEAT: rdata = peripheral_feature_word;
            default:                   hit   = 1'b0;
        endcase
    end

endmodule : dicr_read_mux

// file: dicr_regs_tb.sv
/*
 * self-checking bench for the identity and capability register bank.
 * assumes the bank answers a read one cycle after the read strobe,
 * ignores every write, and captures its straps after reset release.
 */
module dicr_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // stimulus and observation signals
    // ==========================================================
    logic                  core_clk;
    logic                  reset;
    logic                  clk_en;
    dicr_pkg::dicr_strap_t strap_in;
    logic [11:0]           addr;
    logic [31:0]           wdata;
    logic                  wr_stb;
    logic                  rd_stb;
    logic [31:0]           rdata;
    logic                  rd_miss;
    logic                  straps_valid;
    int                    bad_count;
    int                    num_checks;
    logic [11:0]           rq_addr[$];
    logic [31:0]           rq_exp[$];
    logic                  rq_miss[$];

    dicr_regs dicr_regs_i (
        .core_clk     (core_clk),
        .reset        (reset),
        .clk_en       (clk_en),
        .strap_in     (strap_in),
        .addr         (addr),
        .wdata        (wdata),
        .wr_stb       (wr_stb),
        .rd_stb       (rd_stb),
        .rdata        (rdata),
        .rd_miss      (rd_miss),
        .straps_valid (straps_valid)
    );

    // ==========================================================
    // clock, 50 ns period
    // ==========================================================
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // ==========================================================
    // shared helpers
    // ==========================================================
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%08h expected=%08h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        if (bad_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // expected identity word for a given strap setting
    function automatic logic [31:0] id_exp(input logic [2:0] g, input logic [1:0] s);
        return {dicr_pkg::FORMAT_REV_INIT, dicr_pkg::PRODUCT_LINE, dicr_pkg::PRODUCT_NUMBER,
                8'h00, g, dicr_pkg::HOUSING_QFP48, dicr_pkg::LEAD_FREE, s};
    endfunction : id_exp

    task automatic add_read(input logic [11:0] a, input logic [31:0] e, input logic m);
        rq_addr.push_back(a);
        rq_exp.push_back(e);
        rq_miss.push_back(m);
    endtask : add_read

    // back-to-back reads; each answer is looked at in the cycle after its strobe
    task automatic run_reads;
        for (int i = 0; i <= rq_addr.size(); i++) begin
            @(posedge core_clk);
            rd_stb <= (i < rq_addr.size());
            if (i < rq_addr.size()) addr <= rq_addr[i];
            #1;
            if (i > 0) begin
                check(rdata, rq_exp[i-1]);
                check({31'h0, rd_miss}, {31'h0, rq_miss[i-1]});
            end
        end
        @(posedge core_clk);
        #1;
        check(rdata, 32'h0000_0000);
        check({31'h0, rd_miss}, 32'h0000_0000);
        rq_addr.delete();
        rq_exp.delete();
        rq_miss.delete();
    endtask : run_reads

    task automatic write_word(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge core_clk);
        wr_stb <= 1'b0;
    endtask : write_word

    // ==========================================================
    // scenarios
    // ==========================================================
    // reset with given straps, check quiet outputs, wait for capture
    task automatic reset_with_straps(input logic [2:0] g, input logic [1:0] s);
        int n;
        @(posedge core_clk);
        reset    <= 1'b1;
        strap_in <= dicr_pkg::dicr_strap_t'({g, s});
        repeat (7) @(posedge core_clk);
        #1;
        check(rdata, 32'h0000_0000);
        check({30'h0, rd_miss, straps_valid}, 32'h0000_0000);
        @(posedge core_clk);
        reset <= 1'b0;
        n = 0;
        while (straps_valid !== 1'b1 && n < 10) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n >= 10) begin
            bad_count++;
            tally_and_finish();
        end
        check(32'(n), 32'h0000_0002);
    endtask : reset_with_straps

    // all four words read back to back, straps reflected in the identity word
    task automatic read_all_words(input logic [2:0] g, input logic [1:0] s);
        add_read(12'h004, id_exp(g, s), 1'b0);
        add_read(12'h008, 32'h001F_000F, 1'b0);
        add_read(12'h010, 32'h0000_309F, 1'b0);
        add_read(12'h014, 32'h0707_1013, 1'b0);
        run_reads();
    endtask : read_all_words

    // writes of all ones to three words and zero to the core word, then reads after one idle cycle
    task automatic writes_ignored(input logic [2:0] g, input logic [1:0] s);
        write_word(12'h004, 32'hFFFF_FFFF);
        write_word(12'h008, 32'hFFFF_FFFF);
        write_word(12'h010, 32'h0000_0000);
        write_word(12'h014, 32'hFFFF_FFFF);
        read_all_words(g, s);
    endtask : writes_ignored

    // write strobe followed with no gap by a read of the same word
    task automatic write_then_read(input logic [11:0] a, input logic [31:0] e);
        @(posedge core_clk);
        addr   <= a;
        wdata  <= 32'hFFFF_FFFF;
        wr_stb <= 1'b1;
        @(posedge core_clk);
        wr_stb <= 1'b0;
        rd_stb <= 1'b1;
        @(posedge core_clk);
        rd_stb <= 1'b0;
        #1;
        check(rdata, e);
    endtask : write_then_read

    // unmapped and in-between offsets answer zero with a miss
    task automatic unmapped_reads;
        add_read(12'h000, 32'h0000_0000, 1'b1);
        add_read(12'h00C, 32'h0000_0000, 1'b1);
        add_read(12'h008, 32'h001F_000F, 1'b0);
        add_read(12'hFFC, 32'h0000_0000, 1'b1);
        run_reads();
    endtask : unmapped_reads

    // clock enable low freezes the answer
    task automatic enable_hold;
        @(posedge core_clk);
        addr   <= 12'h008;
        rd_stb <= 1'b1;
        @(posedge core_clk);
        rd_stb <= 1'b0;
        clk_en <= 1'b0;
        @(posedge core_clk);
        #1;
        check(rdata, 32'h001F_000F);
        @(posedge core_clk);
        clk_en <= 1'b1;
        @(posedge core_clk);
        #1;
        check(rdata, 32'h0000_0000);
    endtask : enable_hold

    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        bad_count  = 0;
        num_checks = 0;
        reset      = 1'b1;
        clk_en     = 1'b1;
        strap_in   = dicr_pkg::dicr_strap_t'(5'h00);
        addr       = 12'h000;
        wdata      = 32'h0000_0000;
        wr_stb     = 1'b0;
        rd_stb     = 1'b0;
        for (int k = 0; k < 3; k++) begin
            reset_with_straps(3'(k), 2'(2 - k));
            read_all_words(3'(k), 2'(2 - k));
        end
        reset_with_straps(dicr_pkg::GRADE_EXTENDED, dicr_pkg::STATUS_QUALIFIED);
        writes_ignored(dicr_pkg::GRADE_EXTENDED, dicr_pkg::STATUS_QUALIFIED);
        write_then_read(12'h008, 32'h001F_000F);
        write_then_read(12'h010, 32'h0000_309F);
        unmapped_reads();
        enable_hold();
        tally_and_finish();
    end

endmodule : dicr_regs_tb
